/* File: shared/psc_link_if.sv */
// Command and reply link between network master and servo slave
`timescale 1ns/10ps
interface psc_link_if;
	logic req_valid;
	logic [7:0] cmd;
	logic [7:0] dno;
	logic [31:0] data;
	logic rsp_valid;
	logic rsp_err;
	logic rsp_rdis;
	logic rsp_dtype;
	logic [3:0] rsp_dp;
	logic [31:0] rsp_word;
	logic [71:0] rsp_text;
	modport dev (
		input req_valid,
		input cmd,
		input dno,
		input data,
		output rsp_valid,
		output rsp_err,
		output rsp_rdis,
		output rsp_dtype,
		output rsp_dp,
		output rsp_word,
		output rsp_text
	);
	modport host (
		output req_valid,
		output cmd,
		output dno,
		output data,
		input rsp_valid,
		input rsp_err,
		input rsp_rdis,
		input rsp_dtype,
		input rsp_dp,
		input rsp_word,
		input rsp_text
	);
endinterface

/* File: shared/psc_pkg.sv */
// Shared constants for the parameter and status command handler
package psc_pkg;
	// Command codes
	localparam logic [7:0] CMD_STAT = 8'h01;
	localparam logic [7:0] CMD_GRP_RD = 8'h04;
	localparam logic [7:0] CMD_SET_RD = 8'h05;
	localparam logic [7:0] CMD_UPR_RD = 8'h06;
	localparam logic [7:0] CMD_LWR_RD = 8'h07;
	localparam logic [7:0] CMD_NAME_RD = 8'h08;
	localparam logic [7:0] CMD_STAT_CLR = 8'h81;
	localparam logic [7:0] CMD_PAR_WR = 8'h84;
	localparam logic [7:0] CMD_GRP_SEL = 8'h85;
	localparam logic [7:0] CMD_STN_GRP = 8'h9F;
	localparam logic [7:0] DNO_ZERO = 8'h00;
	localparam logic [7:0] DNO_ONE = 8'h01;
	// Status items: data numbers below 80 read names, from 80 read data
	localparam int STAT_DATA_BIT = 7;
	localparam logic [6:0] STAT_LAST = 7'h0E;
	localparam logic [3:0] STAT_CUM = 4'h0;
	localparam logic [15:0] KEY_CLEAR = 16'h1EA5;
	localparam logic [7:0] STN_FIRST = 8'h61;
	localparam logic [7:0] STN_LAST = 8'h66;
	localparam logic [1:0] GRP_BASIC = 2'h0;
	localparam logic [1:0] GRP_IO = 2'h3;
	localparam logic [31:0] GRP_SEL_MAX = 32'h0000_0003;
	// Set data layout: write mode, decimal point position, value
	localparam int WM_HI = 31;
	localparam int WM_LO = 28;
	localparam int DP_HI = 27;
	localparam int DP_LO = 24;
	localparam int VAL_HI = 23;
	localparam logic [3:0] WM_NV = 4'h0;
	localparam logic [3:0] WM_RAM = 4'h3;
	localparam logic [3:0] DP_NONE = 4'hF;
	localparam logic [3:0] DP_HEX = 4'h0;
	localparam logic DT_DEC = 1'b0;
	localparam logic DT_HEX = 1'b1;
	localparam logic [23:0] PAR_UPPER = 24'h004E20;
	localparam logic [23:0] PAR_LOWER = 24'h000000;
	localparam logic [23:0] PROT_OPEN = 24'h000000;
	// Protect setting is basic group parameter 19
	localparam logic [9:0] PROT_ADDR = 10'h013;
	localparam int PAR_WORDS = 1024;
	localparam logic [7:0] ASC_ZERO = 8'h30;
	localparam logic [7:0] ASC_ALPHA = 8'h37;
	// Host register map, byte offsets
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_WDATA = 8'h04;
	localparam logic [7:0] A_CTRL = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_RDATA = 8'h10;
	localparam logic [7:0] A_VALUE = 8'h14;
	localparam logic [7:0] A_TXT0 = 8'h18;
	localparam logic [7:0] A_TXT1 = 8'h1C;
	localparam logic [7:0] A_TXT2 = 8'h20;
	localparam logic [7:0] A_BLANK = 8'h24;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam int ST_DTYPE = 3;
	localparam int ST_RDIS = 4;
	localparam int ST_DP_LO = 8;
	localparam int CTRL_GO = 0;
	typedef enum logic [1:0] {
		PSC_IDLE = 2'b00,
		PSC_SEND = 2'b01,
		PSC_WAIT = 2'b10
	} psc_state_type;
endpackage

/* File: src/psc_device.sv */
// Slave end: decodes commands, keeps parameters and status items
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
// Notes on behaviour
// - Group setting takes letter a to f
// - Every request gets a matching reply
// - Type 0 reply: hex to decimal, place point (host keeps the binary word and only zeroes F digits)
// - Type 1 reply: use data unchanged
// - Decimal write needs point; hex needs zero
// - Status names and units for items 00-0E
// - Status data with type and point
// - 81/00/1EA5 clears cumulative feedback count, only right after a cumulative read
// - Select parameter group 0 to 3 first
// - Command 04/01 returns selected group
// - Command 08 returns nine-character parameter name
// - Data number is parameter number in group
// - Command 05 returns setting with type, point
// - Type 0 with point: F digits blank
// - Protected parameter reads disabled, data zero
// - Commands 06 and 07 return limits
// - Command 84 writes mode, point, value
// - Mode 0 nonvolatile, mode 3 working only
// - Frequent changes should use working mode
// - Master writes within limits, reads back
module psc_device (
	input wire logic ref_clk,
	input wire logic rst,
	psc_link_if.dev lnk,
	input wire logic fb_pulse,
	input wire logic [31:0] mon_value,
	output logic [3:0] mon_sel,
	output logic [7:0] stn_group,
	output logic [1:0] par_group
);
	logic act_r;
	logic [7:0] cmd_r;
	logic [7:0] dno_r;
	logic [31:0] dat_r;
	logic [3:0] mon_sel_r;
	logic [7:0] stn_r;
	logic [1:0] grp_r;
	logic [31:0] cum_r;
	logic [3:0] last_item_r;
	logic [psc_pkg::PAR_WORDS-1:0] wr_ok_r;
	logic [27:0] work_mem [0:psc_pkg::PAR_WORDS-1];
	logic [27:0] nv_mem [0:psc_pkg::PAR_WORDS-1];
	logic rsp_valid_r;
	logic rsp_err_r;
	logic rsp_rdis_r;
	logic rsp_dtype_r;
	logic [3:0] rsp_dp_r;
	logic [31:0] rsp_word_r;
	logic [71:0] rsp_text_r;
	logic err_nxt;
	logic rdis_nxt;
	logic dtype_nxt;
	logic [3:0] dp_nxt;
	logic [31:0] word_nxt;
	logic [71:0] text_nxt;
	logic do_clr;
	logic do_grp;
	logic do_stn;
	logic do_wr;
	logic do_stat_rd;
	logic [9:0] idx;
	logic [27:0] entry;
	logic [23:0] prot_val;
	logic blocked;
	logic hex_grp;
	logic [3:0] wm;
	logic [3:0] wdp;
	logic [23:0] wval;
	logic wr_good;

	function automatic logic [7:0] hexch(input logic [3:0] n);
		if (n < 4'hA)
			hexch = psc_pkg::ASC_ZERO + {4'h0, n};
		else
			hexch = psc_pkg::ASC_ALPHA + {4'h0, n};
	endfunction

	// Capture stage; gives the monitor one cycle to present its item
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			act_r <= 1'b0;
			cmd_r <= 8'h00;
			dno_r <= 8'h00;
			dat_r <= 32'h0000_0000;
			mon_sel_r <= 4'h0;
		end else begin
			act_r <= lnk.req_valid;
			if (lnk.req_valid) begin
				cmd_r <= lnk.cmd;
				dno_r <= lnk.dno;
				dat_r <= lnk.data;
				mon_sel_r <= lnk.dno[3:0];
			end
		end
	end

	assign idx = {grp_r, dno_r};
	assign entry = wr_ok_r[idx] ? work_mem[idx] : 28'h000_0000;
	assign prot_val = wr_ok_r[psc_pkg::PROT_ADDR] ?
		work_mem[psc_pkg::PROT_ADDR][23:0] : psc_pkg::PROT_OPEN;
	assign blocked = (prot_val != psc_pkg::PROT_OPEN) &&
		(grp_r != psc_pkg::GRP_BASIC);
	assign hex_grp = (grp_r == psc_pkg::GRP_IO);
	assign wm = dat_r[psc_pkg::WM_HI:psc_pkg::WM_LO];
	assign wdp = dat_r[psc_pkg::DP_HI:psc_pkg::DP_LO];
	assign wval = dat_r[psc_pkg::VAL_HI:0];
	assign wr_good = (wm == psc_pkg::WM_NV || wm == psc_pkg::WM_RAM) &&
		!blocked && wval <= psc_pkg::PAR_UPPER &&
		wval >= psc_pkg::PAR_LOWER &&
		(hex_grp ? wdp == psc_pkg::DP_HEX : wdp != psc_pkg::DP_NONE);

	always_comb begin
		err_nxt = 1'b0;
		rdis_nxt = 1'b0;
		dtype_nxt = psc_pkg::DT_DEC;
		dp_nxt = 4'h0;
		word_nxt = 32'h0000_0000;
		text_nxt = {9{8'h20}};
		do_clr = 1'b0;
		do_grp = 1'b0;
		do_stn = 1'b0;
		do_wr = 1'b0;
		do_stat_rd = 1'b0;
		case (cmd_r)
			psc_pkg::CMD_STAT: begin
				if (dno_r[6:0] > psc_pkg::STAT_LAST) begin
					err_nxt = 1'b1;
				end else if (!dno_r[psc_pkg::STAT_DATA_BIT]) begin
					text_nxt = {"MON", hexch(dno_r[3:0]), " ", "PLS "};
				end else begin
					do_stat_rd = 1'b1;
					word_nxt = (dno_r[3:0] == psc_pkg::STAT_CUM) ?
						cum_r : mon_value;
				end
			end
			psc_pkg::CMD_GRP_RD: begin
				if (dno_r == psc_pkg::DNO_ONE)
					word_nxt = {30'h0, grp_r};
				else
					err_nxt = 1'b1;
			end
			psc_pkg::CMD_SET_RD, psc_pkg::CMD_UPR_RD,
			psc_pkg::CMD_LWR_RD, psc_pkg::CMD_NAME_RD: begin
				dtype_nxt = hex_grp ? psc_pkg::DT_HEX : psc_pkg::DT_DEC;
				if (blocked) begin
					rdis_nxt = 1'b1;
				end else if (cmd_r == psc_pkg::CMD_NAME_RD) begin
					text_nxt = {"PRM", hexch({2'h0, grp_r}), "_",
						hexch(dno_r[7:4]), hexch(dno_r[3:0]), "  "};
				end else if (cmd_r == psc_pkg::CMD_SET_RD) begin
					dp_nxt = entry[27:24];
					word_nxt = {8'h00, entry[23:0]};
				end else begin
					word_nxt = {8'h00, (cmd_r == psc_pkg::CMD_UPR_RD) ?
						psc_pkg::PAR_UPPER : psc_pkg::PAR_LOWER};
				end
			end
			psc_pkg::CMD_STAT_CLR: begin
				// clear only right after cumulative read
				if (dno_r == psc_pkg::DNO_ZERO &&
					dat_r[15:0] == psc_pkg::KEY_CLEAR &&
					last_item_r == psc_pkg::STAT_CUM)
					do_clr = 1'b1;
				else
					err_nxt = 1'b1;
			end
			psc_pkg::CMD_PAR_WR: begin
				if (wr_good)
					do_wr = 1'b1;
				else
					err_nxt = 1'b1;
			end
			psc_pkg::CMD_GRP_SEL: begin
				if (dno_r == psc_pkg::DNO_ZERO &&
					dat_r <= psc_pkg::GRP_SEL_MAX)
					do_grp = 1'b1;
				else
					err_nxt = 1'b1;
			end
			psc_pkg::CMD_STN_GRP: begin
				if (dno_r == psc_pkg::DNO_ZERO &&
					dat_r[7:0] >= psc_pkg::STN_FIRST &&
					dat_r[7:0] <= psc_pkg::STN_LAST)
					do_stn = 1'b1;
				else
					err_nxt = 1'b1;
			end
			default: err_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rsp_valid_r <= 1'b0;
			rsp_err_r <= 1'b0;
			rsp_rdis_r <= 1'b0;
			rsp_dtype_r <= 1'b0;
			rsp_dp_r <= 4'h0;
			rsp_word_r <= 32'h0000_0000;
			rsp_text_r <= 72'h0;
		end else begin
			rsp_valid_r <= act_r;
			if (act_r) begin
				rsp_err_r <= err_nxt;
				rsp_rdis_r <= rdis_nxt;
				rsp_dtype_r <= dtype_nxt;
				rsp_dp_r <= dp_nxt;
				rsp_word_r <= word_nxt;
				rsp_text_r <= text_nxt;
			end
		end
	end

	// Selections
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stn_r <= psc_pkg::STN_FIRST;
			grp_r <= psc_pkg::GRP_BASIC;
			last_item_r <= 4'hF;
		end else if (act_r) begin
			if (do_stn)
				stn_r <= dat_r[7:0];
			if (do_grp)
				grp_r <= dat_r[1:0];
			if (do_stat_rd)
				last_item_r <= dno_r[3:0];
			else
				last_item_r <= 4'hF;
		end
	end

	// a pulse in the clear cycle is kept
	always_ff @(posedge ref_clk) begin
		if (rst)
			cum_r <= 32'h0000_0000;
		else if (act_r && do_clr)
			cum_r <= {31'h0, fb_pulse};
		else if (fb_pulse)
			cum_r <= cum_r + 32'h0000_0001;
	end

	// mode 0 also updates the nonvolatile copy
	always_ff @(posedge ref_clk) begin
		if (act_r && do_wr) begin
			work_mem[idx] <= {wdp, wval};
			if (wm == psc_pkg::WM_NV)
				nv_mem[idx] <= {wdp, wval};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			wr_ok_r <= '0;
		else if (act_r && do_wr)
			wr_ok_r[idx] <= 1'b1;
	end

	assign mon_sel = mon_sel_r;
	assign stn_group = stn_r;
	assign par_group = grp_r;
	assign lnk.rsp_valid = rsp_valid_r;
	assign lnk.rsp_err = rsp_err_r;
	assign lnk.rsp_rdis = rsp_rdis_r;
	assign lnk.rsp_dtype = rsp_dtype_r;
	assign lnk.rsp_dp = rsp_dp_r;
	assign lnk.rsp_word = rsp_word_r;
	assign lnk.rsp_text = rsp_text_r;
endmodule

/* File: src/psc_host.sv */
// Master end: APB registers issue commands and hold replies
`timescale 1ns/10ps
module psc_host (
	input wire logic ref_clk,
	input wire logic rst,
	psc_link_if.host lnk,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	psc_pkg::psc_state_type state_r;
	logic [15:0] cmd_reg_r;
	logic [31:0] wdata_r;
	logic req_valid_r;
	logic done_r;
	logic err_r;
	logic rdis_r;
	logic dtype_r;
	logic [3:0] dp_r;
	logic [31:0] rdata_r;
	logic [31:0] value_r;
	logic [7:0] blank_r;
	logic [71:0] text_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic setup;
	logic wr_acc;
	logic go;
	logic [31:0] rd_mux;
	logic hit;
	logic [31:0] val_clean;
	logic [7:0] blank_map;

	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign go = wr_acc && paddr == psc_pkg::A_CTRL &&
		pwdata[psc_pkg::CTRL_GO] && state_r == psc_pkg::PSC_IDLE;

	always_comb begin
		hit = 1'b1;
		case (paddr)
			psc_pkg::A_CMD: rd_mux = {16'h0, cmd_reg_r};
			psc_pkg::A_WDATA: rd_mux = wdata_r;
			psc_pkg::A_CTRL: rd_mux = 32'h0000_0000;
			psc_pkg::A_STAT: rd_mux = {20'h0, dp_r, 3'h0, rdis_r, dtype_r,
				err_r, done_r, state_r != psc_pkg::PSC_IDLE};
			psc_pkg::A_RDATA: rd_mux = rdata_r;
			psc_pkg::A_VALUE: rd_mux = value_r;
			psc_pkg::A_TXT0: rd_mux = text_r[31:0];
			psc_pkg::A_TXT1: rd_mux = text_r[63:32];
			psc_pkg::A_TXT2: rd_mux = {24'h0, text_r[71:64]};
			psc_pkg::A_BLANK: rd_mux = {24'h0, blank_r};
			default: begin
				rd_mux = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
	end

	// Answer prepared in setup so access phase needs no wait
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= 1'b1;
			if (setup) begin
				prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_r <= !hit;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd_reg_r <= 16'h0000;
			wdata_r <= 32'h0000_0000;
		end else if (wr_acc && state_r == psc_pkg::PSC_IDLE) begin
			if (paddr == psc_pkg::A_CMD)
				cmd_reg_r <= pwdata[15:0];
			if (paddr == psc_pkg::A_WDATA)
				wdata_r <= pwdata;
		end
	end

	// One request outstanding; next waits for the reply
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= psc_pkg::PSC_IDLE;
			req_valid_r <= 1'b0;
		end else begin
			req_valid_r <= 1'b0;
			case (state_r)
				psc_pkg::PSC_IDLE: begin
					if (go) begin
						state_r <= psc_pkg::PSC_SEND;
						req_valid_r <= 1'b1;
					end
				end
				psc_pkg::PSC_SEND: state_r <= psc_pkg::PSC_WAIT;
				psc_pkg::PSC_WAIT: begin
					if (lnk.rsp_valid)
						state_r <= psc_pkg::PSC_IDLE;
				end
				default: state_r <= psc_pkg::PSC_IDLE;
			endcase
		end
	end

	always_comb begin
		val_clean = lnk.rsp_word;
		blank_map = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (lnk.rsp_dtype == psc_pkg::DT_DEC &&
				lnk.rsp_dp != psc_pkg::DP_HEX &&
				lnk.rsp_word[i*4 +: 4] == 4'hF) begin
				val_clean[i*4 +: 4] = 4'h0;
				blank_map[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_r <= 1'b0;
			rdis_r <= 1'b0;
			dtype_r <= 1'b0;
			dp_r <= 4'h0;
			rdata_r <= 32'h0000_0000;
			value_r <= 32'h0000_0000;
			blank_r <= 8'h00;
			text_r <= 72'h0;
		end else if (state_r == psc_pkg::PSC_WAIT && lnk.rsp_valid) begin
			err_r <= lnk.rsp_err;
			rdis_r <= lnk.rsp_rdis;
			dtype_r <= lnk.rsp_dtype;
			dp_r <= lnk.rsp_dp;
			rdata_r <= lnk.rsp_word;
			text_r <= lnk.rsp_text;
			blank_r <= blank_map;
			value_r <= (lnk.rsp_dtype == psc_pkg::DT_DEC) ?
				val_clean : lnk.rsp_word;
		end
	end

	// Reply event wins over a software clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst)
			done_r <= 1'b0;
		else if (state_r == psc_pkg::PSC_WAIT && lnk.rsp_valid)
			done_r <= 1'b1;
		else if (wr_acc && paddr == psc_pkg::A_STAT &&
			pwdata[psc_pkg::ST_DONE])
			done_r <= 1'b0;
	end

	assign lnk.req_valid = req_valid_r;
	assign lnk.cmd = cmd_reg_r[7:0];
	assign lnk.dno = cmd_reg_r[15:8];
	assign lnk.data = wdata_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule

/* File: tb/parameter_status_command_handler_tb.sv */
// Bench: APB host end joined to the slave end over the link
`timescale 1ns/10ps
module parameter_status_command_handler_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] mon_value = 32'h0;
	logic fb_pulse = 1'b0;
	logic [31:0] prdata, st, rd, bq;
	logic pready, pslverr, perr;
	logic [3:0] mon_sel;
	logic [7:0] stn_group;
	logic [1:0] par_group;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	psc_link_if lnk_if ();
	psc_host u_psc_host (.ref_clk(ref_clk), .rst(rst), .lnk(lnk_if.host),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	psc_device u_psc_device (.ref_clk(ref_clk), .rst(rst), .lnk(lnk_if.dev),
		.fb_pulse(fb_pulse), .mon_value(mon_value), .mon_sel(mon_sel),
		.stn_group(stn_group), .par_group(par_group));
	psc_sva u_psc_sva (.ref_clk(ref_clk), .rst(rst),
		.req_valid(lnk_if.req_valid), .cmd(lnk_if.cmd), .dno(lnk_if.dno),
		.data(lnk_if.data), .rsp_valid(lnk_if.rsp_valid),
		.rsp_err(lnk_if.rsp_err), .rsp_rdis(lnk_if.rsp_rdis),
		.rsp_dtype(lnk_if.rsp_dtype), .rsp_dp(lnk_if.rsp_dp),
		.rsp_word(lnk_if.rsp_word), .rsp_text(lnk_if.rsp_text));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Whole run needs about 1300 cycles; this only catches a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		bq = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Issue one command, poll for done, fetch reply, clear done
	task automatic send(input logic [7:0] c, input logic [7:0] d,
		input logic [31:0] w);
		int n;
		apb(1'b1, psc_pkg::A_CMD, {16'h0000, d, c});
		apb(1'b1, psc_pkg::A_WDATA, w);
		apb(1'b1, psc_pkg::A_CTRL, 32'h0000_0001);
		n = 0;
		st = 32'h0;
		while (st[psc_pkg::ST_DONE] !== 1'b1 && n < 20) begin
			apb(1'b0, psc_pkg::A_STAT, 32'h0);
			st = bq;
			n++;
		end
		chk("done", 32'h1, {31'h0, st[psc_pkg::ST_DONE]});
		apb(1'b0, psc_pkg::A_RDATA, 32'h0);
		rd = bq;
		apb(1'b1, psc_pkg::A_STAT, 32'h0000_0002);
	endtask
	task automatic ex_err(input logic e);
		chk("error flag", {31'h0, e}, {31'h0, st[psc_pkg::ST_ERR]});
	endtask
	task automatic t_groups();
		for (int i = 0; i < 4; i++) begin
			send(psc_pkg::CMD_GRP_SEL, 8'h00, 32'(i));
			ex_err(1'b0);
			chk("par_group", 32'(i), {30'h0, par_group});
			send(psc_pkg::CMD_GRP_RD, 8'h01, 32'h0);
			chk("group read", 32'(i), rd);
		end
		send(psc_pkg::CMD_GRP_SEL, 8'h00, 32'h0000_0004);
		ex_err(1'b1);
		chk("group kept", 32'h3, {30'h0, par_group});
		send(psc_pkg::CMD_GRP_SEL, 8'h00, 32'h0);
		$display("groups test done");
	endtask
	task automatic t_station();
		chk("station reset", 32'h61, {24'h0, stn_group});
		for (int i = 8'h61; i <= 8'h67; i++) begin
			send(psc_pkg::CMD_STN_GRP, 8'h00, 32'(i));
			ex_err(i == 8'h67);
			chk("station", 32'(i == 8'h67 ? 8'h66 : i), {24'h0, stn_group});
		end
		$display("station test done");
	endtask
	task automatic t_status();
		mon_value <= 32'hCAFE0123;
		for (int i = 0; i < 16; i++) begin
			send(psc_pkg::CMD_STAT, 8'(i), 32'h0);
			ex_err(i == 15);
		end
		send(psc_pkg::CMD_STAT, 8'h83, 32'h0);
		chk("monitor", 32'hCAFE0123, rd);
		chk("mon_sel", 32'h3, {28'h0, mon_sel});
		fb_pulse <= 1'b1;
		repeat (5) @(posedge ref_clk);
		fb_pulse <= 1'b0;
		send(psc_pkg::CMD_STAT, 8'h80, 32'h0);
		chk("pulse count", 32'h5, rd);
		send(psc_pkg::CMD_STAT_CLR, 8'h00, 32'h0000_1EA5);
		ex_err(1'b0);
		send(psc_pkg::CMD_STAT, 8'h80, 32'h0);
		chk("cleared count", 32'h0, rd);
		send(psc_pkg::CMD_STAT_CLR, 8'h00, 32'h0000_1EA4);
		ex_err(1'b1);
		send(psc_pkg::CMD_GRP_RD, 8'h01, 32'h0);
		send(psc_pkg::CMD_STAT_CLR, 8'h00, 32'h0000_1EA5);
		ex_err(1'b1);
		$display("status test done");
	endtask
	task automatic t_param();
		logic [31:0] bad [3] = '{32'h2000_0077, 32'h3100_4E21, 32'h3F00_0077};
		send(psc_pkg::CMD_PAR_WR, 8'h05, 32'h0100_0123);
		ex_err(1'b0);
		send(psc_pkg::CMD_SET_RD, 8'h05, 32'h0);
		chk("setting", 32'h0000_0123, rd);
		chk("point", 32'h1, {28'h0, st[11:8]});
		send(psc_pkg::CMD_PAR_WR, 8'h05, 32'h3000_0456);
		ex_err(1'b0);
		for (int i = 0; i < 3; i++) begin
			send(psc_pkg::CMD_PAR_WR, 8'h05, bad[i]);
			ex_err(1'b1);
		end
		send(psc_pkg::CMD_SET_RD, 8'h05, 32'h0);
		chk("kept setting", 32'h0000_0456, rd);
		send(psc_pkg::CMD_PAR_WR, 8'h06, 32'h0100_0FF3);
		send(psc_pkg::CMD_SET_RD, 8'h06, 32'h0);
		chk("raw data", 32'h0000_0FF3, rd);
		apb(1'b0, psc_pkg::A_VALUE, 32'h0);
		chk("blanked value", 32'h0000_0003, bq);
		apb(1'b0, psc_pkg::A_BLANK, 32'h0);
		chk("blank mask", 32'h0000_0006, bq);
		send(psc_pkg::CMD_UPR_RD, 8'h05, 32'h0);
		chk("upper", 32'h0000_4E20, {8'h0, rd[23:0]});
		send(psc_pkg::CMD_LWR_RD, 8'h05, 32'h0);
		chk("lower", 32'h0, {8'h0, rd[23:0]});
		send(psc_pkg::CMD_NAME_RD, 8'h05, 32'h0);
		chk("name", 32'h50524D, {8'h0, lnk_if.rsp_text[71:48]});
		apb(1'b0, psc_pkg::A_TXT0, 32'h0);
		chk("name tail", 32'h3035_2020, bq);
		send(psc_pkg::CMD_GRP_SEL, 8'h00, 32'h3);
		send(psc_pkg::CMD_PAR_WR, 8'h05, 32'h3100_0010);
		ex_err(1'b1);
		send(psc_pkg::CMD_PAR_WR, 8'h05, 32'h3000_0010);
		send(psc_pkg::CMD_SET_RD, 8'h05, 32'h0);
		chk("hex type", 32'h1, {31'h0, st[psc_pkg::ST_DTYPE]});
		apb(1'b0, psc_pkg::A_VALUE, 32'h0);
		chk("hex value", 32'h0000_0010, bq);
		send(psc_pkg::CMD_GRP_SEL, 8'h00, 32'h0);
		send(psc_pkg::CMD_SET_RD, 8'h05, 32'h0);
		chk("group index", 32'h0000_0456, rd);
		send(psc_pkg::CMD_PAR_WR, 8'h13, 32'h3000_0001);
		send(psc_pkg::CMD_GRP_SEL, 8'h00, 32'h1);
		send(psc_pkg::CMD_SET_RD, 8'h05, 32'h0);
		chk("read disable", 32'h1, {31'h0, st[psc_pkg::ST_RDIS]});
		chk("blocked data", 32'h0, rd);
		$display("parameter test done");
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, perr});
		chk("unmapped data", 32'h0, bq);
		t_station();
		t_groups();
		t_status();
		t_param();
		report_and_stop();
	end
endmodule

/* File: tb/psc_sva.sv */
// Link-level protocol checker for the command handler
`timescale 1ns/10ps
module psc_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [7:0] cmd,
	input wire logic [7:0] dno,
	input wire logic [31:0] data,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic rsp_rdis,
	input wire logic rsp_dtype,
	input wire logic [3:0] rsp_dp,
	input wire logic [31:0] rsp_word,
	input wire logic [71:0] rsp_text
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// A request of the given kind, then its reply two edges later
	sequence s_ans(cond);
		req_valid && cond ##2 rsp_valid;
	endsequence
	chk_rsp_latency: assert property (req_valid |-> ##2 rsp_valid)
		else $error("reply not two cycles after request");
	chk_rsp_cause: assert property (rsp_valid |-> $past(req_valid, 2))
		else $error("reply without request");
	// Reply error flag and word must stand between replies, not drift
	chk_reply_holds: assert property (!rsp_valid |-> $stable(rsp_err)
		&& $stable(rsp_word)) else $error("reply fields changed");
	chk_grp_code: assert property (s_ans(cmd == psc_pkg::CMD_GRP_RD
		&& dno == psc_pkg::DNO_ONE) |-> !rsp_err && rsp_word[31:2] == 30'h0)
		else $error("group code wrong");
	chk_stat_name: assert property (s_ans(cmd == psc_pkg::CMD_STAT
		&& dno <= 8'h0E) |-> !rsp_err && rsp_text[71:48] == 24'h4D4F4E)
		else $error("status name wrong");
	chk_par_name: assert property (s_ans(cmd == psc_pkg::CMD_NAME_RD)
		|-> rsp_rdis || rsp_text[71:48] == 24'h50524D)
		else $error("name text wrong");
	chk_upper_lim: assert property (s_ans(cmd == psc_pkg::CMD_UPR_RD)
		|-> rsp_rdis || rsp_word[23:0] == psc_pkg::PAR_UPPER)
		else $error("upper limit wrong");
	chk_rdis_zero: assert property (rsp_valid && rsp_rdis
		|-> rsp_word == 32'h0) else $error("protected read not zero");
	chk_bad_mode: assert property (s_ans(cmd == psc_pkg::CMD_PAR_WR
		&& data[31:28] != psc_pkg::WM_NV && data[31:28] != psc_pkg::WM_RAM)
		|-> rsp_err) else $error("bad write mode accepted");
	chk_dp_missing: assert property (s_ans(cmd == psc_pkg::CMD_PAR_WR
		&& data[27:24] == psc_pkg::DP_NONE) |-> rsp_err)
		else $error("missing point accepted");
	chk_grp_range: assert property (s_ans(cmd == psc_pkg::CMD_GRP_SEL
		&& data > psc_pkg::GRP_SEL_MAX) |-> rsp_err)
		else $error("bad group accepted");
	chk_stn_range: assert property (s_ans(cmd == psc_pkg::CMD_STN_GRP
		&& (data[7:0] < psc_pkg::STN_FIRST || data[7:0] > psc_pkg::STN_LAST))
		|-> rsp_err) else $error("bad station group accepted");
	// Hex data always carries point position zero
	chk_hex_point: assert property (rsp_valid && !rsp_err
		&& rsp_dtype == psc_pkg::DT_HEX |-> rsp_dp == psc_pkg::DP_HEX)
		else $error("hex reply with nonzero point");
endmodule
